// [verilog/sdd_pkg.sv]
// Purpose: Constants and types for the serial data, divider and flag clear bank
// Assumes: APB with 32-bit data and pstrb byte lanes
// Notes:   Offsets are word indexes; byte address is four times the index
package sdd_pkg;
  localparam int NCH = 4;
  // Register word indexes
  localparam logic [19:0] IDX_DATA0 = 20'hf_ff10;
  localparam logic [19:0] IDX_DATA1 = 20'hf_ff12;
  localparam logic [19:0] IDX_DATA2 = 20'hf_ff44;
  localparam logic [19:0] IDX_DATA3 = 20'hf_ff46;
  localparam logic [19:0] IDX_CLR0  = 20'hf_0108;
  localparam logic [19:0] IDX_CLR1  = 20'hf_010a;
  localparam logic [19:0] IDX_CLR2  = 20'hf_010c;
  localparam logic [19:0] IDX_CLR3  = 20'hf_010e;
  localparam logic [19:0] IDX_CTRL  = 20'hf_0130;
  localparam logic [19:0] IDX_STAT  = 20'hf_0132;
  localparam logic [3:0][19:0] IDX_DATA = {IDX_DATA3, IDX_DATA2, IDX_DATA1, IDX_DATA0};
  localparam logic [3:0][19:0] IDX_CLR  = {IDX_CLR3, IDX_CLR2, IDX_CLR1, IDX_CLR0};
  // Data register fields
  localparam int DIV_LSB = 9;
  localparam int DIV_W   = 7;
  localparam int BUF_W   = 9;
  localparam logic [8:0] BUF_MASK_WIDE   = 9'h1ff;
  localparam logic [8:0] BUF_MASK_NARROW = 9'h0ff;
  // Clear trigger fields
  localparam int FE_BIT = 2;
  localparam int PE_BIT = 1;
  localparam int OV_BIT = 0;
  // Control and status fields
  localparam int CTRL_START_LSB = 0;
  localparam int CTRL_STOP_LSB  = 4;
  localparam int CTRL_CCS_LSB   = 8;
  localparam int STAT_EN_LSB    = 16;
  // Reset values
  localparam logic [8:0]  BUF_RST = 9'h000;
  localparam logic [6:0]  DIV_RST = 7'h00;
  localparam logic [15:0] REG_RST = 16'h0000;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic framing;
    logic parity;
    logic overrun;
  } sdd_err_t;
endpackage

// [verilog/sdd_bank.sv]
// Purpose: Four-channel serial data buffers, transfer clock dividers, error flag clear triggers
// Assumes: APB slave, one wait state; shift registers and error detectors sit outside
// Notes:   Error flags and channel enables are kept here and exported
// Functional notes
// - Channels 0,1 buffer 9 bits, channels 2,3 buffer 8; bits 15..9 divider.
// - With clock source 0, transfer clock is operation clock over 2*(divider+1).
// - With clock source 1, divider counter held at zero and external shift clock pin used.
// - Received word stored to buffer; written buffer word feeds the shift register.
// - Divider writable only while channel disabled; enabled writes touch buffer only.
// - Reads while enabled return zero in the divider field.
// - Reset clears the whole data register to zero.
// - Low-byte-only write while stopped clears the divider field.
// - Writing 1 to a clear trigger clears the matching error flag.
// - Clear triggers self-clear once their flag is cleared.
// - Framing clear trigger exists only on channels 1 and 3.
// - Clear trigger register always reads zero.
// - Reset clears the clear trigger register.
// - Clear trigger register accepts 16-bit and low 8-bit writes.
// - Data register supports 16-bit reads and writes.
// - Start trigger sets channel enabled; trigger self-clears once enabled.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
module sdd_bank (
  input  wire logic                     clk_in,
  input  wire logic                     srst_in,
  input  wire logic [31:0]              paddr_in,
  input  wire logic                     psel_in,
  input  wire logic                     penable_in,
  input  wire logic                     pwrite_in,
  input  wire logic [31:0]              pwdata_in,
  input  wire logic [3:0]               pstrb_in,
  output logic      [31:0]              prdata_out,
  output logic                          pready_out,
  output logic                          pslverr_out,
  input  wire logic [3:0]               shift_clock_pin_in,
  output logic      [3:0]               transfer_clk_out,
  input  wire logic [3:0]               rx_store_in,
  input  wire logic [3:0][8:0]          rx_word_in,
  output logic      [3:0][8:0]          tx_word_out,
  input  wire sdd_pkg::sdd_err_t [3:0]  err_set_in,
  output sdd_pkg::sdd_err_t      [3:0]  err_flags_out,
  output logic      [3:0]               channel_enabled_out
);

  logic                     pready_r;
  logic [31:0]              prdata_r;
  logic                     pslverr_r;
  logic [8:0]               buf_r   [4];
  logic [6:0]               div_r   [4];
  logic [6:0]               cnt_r   [4];
  logic [3:0]               tclk_r;
  logic [3:0]               pin_s1_r;
  logic [3:0]               pin_s2_r;
  sdd_pkg::sdd_err_t [3:0]  flag_r;
  sdd_pkg::sdd_err_t [3:0]  trig_r;
  logic [3:0]               start_r;
  logic [3:0]               en_r;
  logic [3:0]               ccs_r;
  logic [19:0]              idx;
  logic                     addr_ok;
  logic                     wr_fire;
  logic                     full16;
  logic                     low8;
  logic                     wr_ctrl;
  logic [31:0]              rd_val;
  logic                     rd_hit;

  assign idx     = paddr_in[21:2];
  assign addr_ok = (paddr_in[31:22] == 10'h000) && (paddr_in[1:0] == 2'b00);
  assign wr_fire = psel_in && penable_in && pready_r && pwrite_in;
  assign full16  = (pstrb_in[1:0] == 2'b11);
  assign low8    = (pstrb_in[1:0] == 2'b01);
  assign wr_ctrl = wr_fire && addr_ok && (idx == sdd_pkg::IDX_CTRL) && pstrb_in[0];

  // Read mux
  always_comb begin
    rd_val = sdd_pkg::RD_ZERO;
    rd_hit = 1'b0;
    if (addr_ok) begin
      for (int c = 0; c < sdd_pkg::NCH; c++) begin
        if (idx == sdd_pkg::IDX_DATA[c]) begin
          rd_hit           = 1'b1;
          rd_val[8:0]      = buf_r[c];
          rd_val[15:9]     = en_r[c] ? sdd_pkg::DIV_RST : div_r[c];
        end
        if (idx == sdd_pkg::IDX_CLR[c]) begin
          rd_hit = 1'b1;
        end
      end
      if (idx == sdd_pkg::IDX_CTRL) begin
        rd_hit = 1'b1;
        rd_val[sdd_pkg::CTRL_CCS_LSB +: 4] = ccs_r;
      end
      if (idx == sdd_pkg::IDX_STAT) begin
        rd_hit = 1'b1;
        for (int c = 0; c < sdd_pkg::NCH; c++) begin
          rd_val[4*c +: 3] = flag_r[c];
        end
        rd_val[sdd_pkg::STAT_EN_LSB +: 4] = en_r;
      end
    end
  end

  // APB answer: one wait state
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pready_r  <= 1'b0;
      prdata_r  <= sdd_pkg::RD_ZERO;
      pslverr_r <= 1'b0;
    end else if (psel_in && penable_in && !pready_r) begin
      pready_r  <= 1'b1;
      prdata_r  <= pwrite_in ? sdd_pkg::RD_ZERO : rd_val;
      pslverr_r <= !rd_hit;
    end else begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  assign prdata_out  = prdata_r;
  assign pready_out  = pready_r;
  assign pslverr_out = pready_r && pslverr_r;

  // Clock source select
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ccs_r <= 4'h0;
    end else if (wr_ctrl && pstrb_in[1]) begin
      ccs_r <= pwdata_in[sdd_pkg::CTRL_CCS_LSB +: 4];
    end
  end

  // Start trigger and enabled status
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      start_r <= 4'h0;
    end else if (wr_ctrl) begin
      start_r <= pwdata_in[sdd_pkg::CTRL_START_LSB +: 4] & ~en_r;
    end else begin
      start_r <= start_r & ~en_r;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      en_r <= 4'h0;
    end else if (wr_ctrl) begin
      en_r <= (en_r | start_r) & ~pwdata_in[sdd_pkg::CTRL_STOP_LSB +: 4];
    end else begin
      en_r <= en_r | start_r;
    end
  end

  // Pin synchroniser
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pin_s1_r <= 4'h0;
      pin_s2_r <= 4'h0;
    end else begin
      pin_s1_r <= shift_clock_pin_in;
      pin_s2_r <= pin_s1_r;
    end
  end

  for (genvar c = 0; c < sdd_pkg::NCH; c++) begin : g_ch
    localparam logic [8:0] MASK = (c < 2) ? sdd_pkg::BUF_MASK_WIDE : sdd_pkg::BUF_MASK_NARROW;
    localparam logic       HAS_FE = (c == 1) || (c == 3);
    logic data_wr;
    logic clr_wr;
    assign data_wr = wr_fire && addr_ok && (idx == sdd_pkg::IDX_DATA[c]);
    assign clr_wr  = wr_fire && addr_ok && (idx == sdd_pkg::IDX_CLR[c]) && pstrb_in[0];

    // Buffer bits
    always_ff @(posedge clk_in) begin
      if (srst_in) begin
        buf_r[c] <= sdd_pkg::BUF_RST;
      end else if (rx_store_in[c]) begin
        buf_r[c] <= rx_word_in[c] & MASK;
      end else if (data_wr && full16) begin
        buf_r[c] <= pwdata_in[8:0] & MASK;
      end else if (data_wr && low8) begin
        buf_r[c] <= {buf_r[c][8], pwdata_in[7:0]} & MASK;
      end
    end

    // Divider field
    always_ff @(posedge clk_in) begin
      if (srst_in) begin
        div_r[c] <= sdd_pkg::DIV_RST;
      end else if (data_wr && !en_r[c] && full16) begin
        div_r[c] <= pwdata_in[sdd_pkg::DIV_LSB +: sdd_pkg::DIV_W];
      end else if (data_wr && !en_r[c] && low8) begin
        div_r[c] <= sdd_pkg::DIV_RST;
      end
    end

    // Transfer clock divider
    always_ff @(posedge clk_in) begin
      if (srst_in || !en_r[c] || ccs_r[c]) begin
        cnt_r[c]  <= sdd_pkg::DIV_RST;
        tclk_r[c] <= 1'b0;
      end else if (cnt_r[c] == div_r[c]) begin
        cnt_r[c]  <= sdd_pkg::DIV_RST;
        tclk_r[c] <= !tclk_r[c];
      end else begin
        cnt_r[c]  <= cnt_r[c] + 7'd1;
      end
    end

    assign transfer_clk_out[c] = ccs_r[c] ? pin_s2_r[c] : tclk_r[c];
    assign tx_word_out[c]      = buf_r[c];

    // Clear triggers
    always_ff @(posedge clk_in) begin
      if (srst_in) begin
        trig_r[c] <= '0;
      end else if (clr_wr) begin
        trig_r[c] <= {pwdata_in[sdd_pkg::FE_BIT] && HAS_FE,
                      pwdata_in[sdd_pkg::PE_BIT],
                      pwdata_in[sdd_pkg::OV_BIT]};
      end else begin
        trig_r[c] <= trig_r[c] & flag_r[c];
      end
    end

    // Error flags
    always_ff @(posedge clk_in) begin
      if (srst_in) begin
        flag_r[c] <= '0;
      end else begin
        flag_r[c].framing <= HAS_FE && (flag_r[c].framing || err_set_in[c].framing) && !trig_r[c].framing;
        flag_r[c].parity  <= (flag_r[c].parity  || err_set_in[c].parity)  && !trig_r[c].parity;
        flag_r[c].overrun <= (flag_r[c].overrun || err_set_in[c].overrun) && !trig_r[c].overrun;
      end
    end
  end

  assign err_flags_out       = flag_r;
  assign channel_enabled_out = en_r;

  chk_clr_reads_zero: assert property (@(posedge clk_in) disable iff (srst_in)
    psel_in && penable_in && !pwrite_in && addr_ok && idx == sdd_pkg::IDX_CLR1 && !pready_r
    |=> pready_out && prdata_out == sdd_pkg::RD_ZERO)
    else $error("clear trigger register read not zero");

  chk_div_locked: assert property (@(posedge clk_in) disable iff (srst_in)
    en_r[0] && $past(en_r[0]) |-> $stable(div_r[0]))
    else $error("divider changed while enabled");

  chk_div_read_hidden: assert property (@(posedge clk_in) disable iff (srst_in)
    psel_in && penable_in && !pwrite_in && addr_ok && idx == sdd_pkg::IDX_DATA0 && !pready_r && en_r[0]
    |=> prdata_out[15:9] == 7'h00)
    else $error("divider visible while enabled");

  chk_flag_cleared: assert property (@(posedge clk_in) disable iff (srst_in)
    trig_r[1].overrun |=> !flag_r[1].overrun)
    else $error("overrun flag not cleared by trigger");

  chk_trig_selfclear: assert property (@(posedge clk_in) disable iff (srst_in)
    $rose(trig_r[1].parity) && !(wr_fire && idx == sdd_pkg::IDX_CLR1) ##1 !(wr_fire && idx == sdd_pkg::IDX_CLR1)
    |-> ##1 !trig_r[1].parity)
    else $error("clear trigger stuck");

  chk_start_enables: assert property (@(posedge clk_in) disable iff (srst_in)
    start_r[0] && !wr_ctrl |=> en_r[0] ##1 !start_r[0])
    else $error("start trigger did not enable channel");

  chk_fe_absent: assert property (@(posedge clk_in) disable iff (srst_in)
    !flag_r[0].framing && !flag_r[2].framing && !trig_r[2].framing)
    else $error("framing flag on channel without it");

  chk_narrow_bit8: assert property (@(posedge clk_in) disable iff (srst_in)
    buf_r[2][8] == 1'b0 && buf_r[3][8] == 1'b0)
    else $error("bit 8 set on narrow channel");

  chk_reset_clears: assert property (@(posedge clk_in)
    srst_in |=> buf_r[0] == sdd_pkg::BUF_RST && div_r[0] == sdd_pkg::DIV_RST && trig_r[0] == '0)
    else $error("reset did not clear registers");

  chk_div_count: assert property (@(posedge clk_in) disable iff (srst_in)
    en_r[0] && !ccs_r[0] && cnt_r[0] == div_r[0] && $stable(div_r[0]) |=> $changed(tclk_r[0]))
    else $error("transfer clock toggle missed");

  chk_low_write_div: assert property (@(posedge clk_in) disable iff (srst_in)
    wr_fire && addr_ok && idx == sdd_pkg::IDX_DATA2 && low8 && !en_r[2] |=> div_r[2] == 7'h00)
    else $error("low byte write kept divider");

  chk_clear_wins: assert property (@(posedge clk_in) disable iff (srst_in)
    trig_r[0].parity && err_set_in[0].parity |=> !flag_r[0].parity)
    else $error("error set beat clear trigger");

  chk_ready_wait: assert property (@(posedge clk_in) disable iff (srst_in)
    psel_in && penable_in && !pready_r |=> pready_out)
    else $error("ready not given after one wait state");

  chk_ready_pulse: assert property (@(posedge clk_in) disable iff (srst_in)
    pready_out |=> !pready_out)
    else $error("ready held longer than one cycle");

  chk_rx_store: assert property (@(posedge clk_in) disable iff (srst_in)
    rx_store_in[0] |=> tx_word_out[0] == $past(rx_word_in[0]))
    else $error("received word not stored");

  chk_rx_narrow: assert property (@(posedge clk_in) disable iff (srst_in)
    rx_store_in[2] |=> tx_word_out[2] == {1'b0, $past(rx_word_in[2][7:0])})
    else $error("narrow channel stored wrong word");

  chk_data_write: assert property (@(posedge clk_in) disable iff (srst_in)
    wr_fire && addr_ok && idx == sdd_pkg::IDX_DATA1 && full16 && !rx_store_in[1] |=> tx_word_out[1] == $past(pwdata_in[8:0]))
    else $error("buffer write lost");

  chk_div_write: assert property (@(posedge clk_in) disable iff (srst_in)
    wr_fire && addr_ok && idx == sdd_pkg::IDX_DATA1 && full16 && !en_r[1] |=> div_r[1] == $past(pwdata_in[15:9]))
    else $error("divider write lost while stopped");

  chk_div_frozen: assert property (@(posedge clk_in) disable iff (srst_in)
    wr_fire && addr_ok && idx == sdd_pkg::IDX_DATA1 && en_r[1] |=> $stable(div_r[1]))
    else $error("divider written while enabled");

  chk_cnt_bound: assert property (@(posedge clk_in) disable iff (srst_in)
    en_r[1] && !ccs_r[1] |-> cnt_r[1] <= div_r[1])
    else $error("divider counter passed its limit");

  chk_ext_clock: assert property (@(posedge clk_in) disable iff (srst_in)
    ccs_r[3] && $past(ccs_r[3]) |-> transfer_clk_out[3] == $past(shift_clock_pin_in[3], 2))
    else $error("external shift clock not passed through");

  chk_flag_sets: assert property (@(posedge clk_in) disable iff (srst_in)
    err_set_in[3].parity && !trig_r[3].parity |=> flag_r[3].parity)
    else $error("parity flag not set");

  chk_clr_low_byte: assert property (@(posedge clk_in) disable iff (srst_in)
    wr_fire && addr_ok && idx == sdd_pkg::IDX_CLR3 && pstrb_in[0] && pwdata_in[sdd_pkg::FE_BIT] |=> trig_r[3].framing)
    else $error("low byte clear trigger write lost");

  chk_trig_reset: assert property (@(posedge clk_in)
    srst_in |=> trig_r[1] == '0 && trig_r[3] == '0 && flag_r[1] == '0)
    else $error("reset did not clear triggers");

endmodule // sdd_bank

// [sim/sdd_peer.sv]
// Purpose: Line-side serial peer for the data, divider and flag clear bank
// Assumes: Outputs change just after rising edges of the bench clock
// Notes:   Shift clock stands still between frames; released word lines show inverse
`timescale 1ns/1ps
module sdd_peer (
  input  wire logic                clk_in,
  output logic [3:0]               sck_out,
  output logic [3:0]               store_out,
  output logic [3:0][8:0]          word_out,
  output sdd_pkg::sdd_err_t [3:0]  err_out
);
  initial begin
    sck_out = '0;
    store_out = '0;
    word_out = '0;
    err_out = '0;
  end

  // One-cycle store pulse, then the released word goes to its inverse
  task automatic rx(input int c, input logic [8:0] w);
    @(posedge clk_in);
    store_out[c] <= 1'b1;
    word_out[c] <= w;
    @(posedge clk_in);
    store_out[c] <= 1'b0;
    word_out[c] <= ~w;
  endtask

  task automatic err(input int c, input sdd_pkg::sdd_err_t e);
    @(posedge clk_in);
    err_out[c] <= e;
    @(posedge clk_in);
    err_out[c] <= '0;
  endtask

  task automatic pin(input int c, input logic v);
    @(posedge clk_in);
    sck_out[c] <= v;
  endtask
endmodule // sdd_peer

// [sim/serial_data_divider_and_flag_clear_tb.sv]
// Purpose: Self-checking bench for the data, divider and flag clear bank
// Assumes: APB master with setup and access phases, peer model on the line side
// Notes:   Random data from a fixed-seed shift register function
`timescale 1ns/1ps
module serial_data_divider_and_flag_clear_tb;
  logic                    clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic                    pready, pslverr, sl;
  logic [31:0]             paddr = '0, pwdata = '0, prdata, rv, seed = 32'h1410_9e1a;
  logic [3:0]              pstrb = '0, sck, store, tclk, en;
  logic [3:0][8:0]         word, txw;
  sdd_pkg::sdd_err_t [3:0] eset, eflg;
  logic [15:0]             sav [4];
  logic [2:0]              ef;
  int                      failures = 0, total_checks = 0, n;

  always #5 clk = ~clk;

  sdd_bank sdd_bank_i (.clk_in(clk), .srst_in(srst), .paddr_in(paddr), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata), .pstrb_in(pstrb),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .shift_clock_pin_in(sck),
    .transfer_clk_out(tclk), .rx_store_in(store), .rx_word_in(word), .tx_word_out(txw),
    .err_set_in(eset), .err_flags_out(eflg), .channel_enabled_out(en));
  sdd_peer sdd_peer_i (.clk_in(clk), .sck_out(sck), .store_out(store), .word_out(word),
    .err_out(eset));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [19:0] ix, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {10'h000, ix, 2'b00};
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rv = prdata;
    sl = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Cycles between two rising edges of one transfer clock
  task automatic period(input int c, output int p);
    logic q;
    int k, f;
    k = 0;
    f = -1;
    p = -1;
    q = tclk[c];
    while (k < 700) begin
      @(posedge clk) k++;
      if (tclk[c] && !q) begin
        if (f >= 0) break;
        f = k;
      end
      q = tclk[c];
    end
    if (f >= 0 && k < 700) p = k - f;
  endtask

  task automatic complete_run;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    complete_run;
  end

  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      apb(0, sdd_pkg::IDX_DATA[c], '0, '0);
      chk("data reset", 32'h0000_0000, rv);
      apb(0, sdd_pkg::IDX_CLR[c], '0, '0);
      chk("clear reset", 32'h0000_0000, rv);
    end
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      int c;
      c = i % 4;
      seed = lfsr(seed);
      sav[c] = seed[15:0];
      if (c > 1) sav[c][8] = 1'b0;
      if (sav[c][15:9] < 7'h02) sav[c][15:9] = 7'h02;
      apb(1, sdd_pkg::IDX_DATA[c], {16'h0000, sav[c]}, 4'b0011);
      apb(0, sdd_pkg::IDX_DATA[c], '0, '0);
      chk("data rw", {16'h0000, sav[c]}, rv);
      chk("tx word", {23'h00_0000, sav[c][8:0]}, {23'h00_0000, txw[c]});
    end
    $display("test random data done");
    apb(1, sdd_pkg::IDX_DATA[2], 32'h0000_00a5, 4'b0001);
    apb(0, sdd_pkg::IDX_DATA[2], '0, '0);
    chk("low byte write", 32'h0000_00a5, rv);
    $display("test low byte done");
    for (int i = 0; i < 2; i++) begin
      apb(1, sdd_pkg::IDX_DATA[i], i ? 32'h0000_fe00 : 32'h0000_0000, 4'b0011);
      apb(1, sdd_pkg::IDX_CTRL, 32'h0000_0001 << i, 4'b0001);
      period(i, n);
      chk("divider period", i ? 256 : 2, n);
      apb(0, sdd_pkg::IDX_STAT, '0, '0);
      chk("enabled", 32'h0000_0001, 32'(rv[16 + i]));
      chk("enabled port", 32'h0000_0001, {31'h0000_0000, en[i]});
    end
    $display("test divider done");
    apb(1, sdd_pkg::IDX_DATA[1], 32'h0000_0255, 4'b0011);
    apb(0, sdd_pkg::IDX_DATA[1], '0, '0);
    chk("divider hidden", 32'h0000_0055, rv);
    apb(1, sdd_pkg::IDX_CTRL, 32'h0000_0020, 4'b0001);
    repeat (3) @(posedge clk);
    apb(0, sdd_pkg::IDX_DATA[1], '0, '0);
    chk("divider kept", 32'h0000_fe55, rv);
    $display("test enabled write done");
    for (int c = 0; c < 4; c += 2) begin
      sdd_peer_i.rx(c, 9'h1c3);
      apb(0, sdd_pkg::IDX_DATA[c], '0, '0);
      chk("rx store", c ? 32'h0000_00c3 : 32'h0000_01c3, rv);
    end
    $display("test receive done");
    for (int c = 0; c < 4; c++) begin
      ef = (c % 2) ? 3'b111 : 3'b011;
      sdd_peer_i.err(c, 3'b111);
      apb(1, sdd_pkg::IDX_CLR[c], 32'h0000_0000, 4'b0011);
      for (int b = 0; b < 4; b++) begin
        repeat (2) @(posedge clk);
        apb(0, sdd_pkg::IDX_STAT, '0, '0);
        chk("error flags", {29'h0000_0000, ef}, {29'h0000_0000, rv[4 * c +: 3]});
        chk("flag port", {29'h0000_0000, ef}, {29'h0000_0000, eflg[c]});
        apb(0, sdd_pkg::IDX_CLR[c], '0, '0);
        chk("clear reads zero", 32'h0000_0000, rv);
        if (b < 3 && ef[b]) apb(1, sdd_pkg::IDX_CLR[c], 32'h0000_0001 << b, b ? 4'b0011 : 4'b0001);
        if (b < 3) ef[b] = 1'b0;
      end
    end
    // Parity set lands while its clear trigger still stands
    sdd_peer_i.err(0, 3'b010);
    apb(1, sdd_pkg::IDX_CLR[0], 32'h0000_0002, 4'b0001);
    sdd_peer_i.err(0, 3'b010);
    apb(0, sdd_pkg::IDX_STAT, '0, '0);
    chk("clear wins", 32'h0000_0000, {29'h0000_0000, rv[2:0]});
    $display("test flag clear done");
    apb(1, sdd_pkg::IDX_DATA[3], 32'h0000_0000, 4'b0011);
    apb(1, sdd_pkg::IDX_CTRL, 32'h0000_0808, 4'b0011);
    for (int k = 0; k < 4; k++) begin
      sdd_peer_i.pin(3, ~k[0]);
      repeat (4) @(posedge clk);
      chk("external clock", {31'h0000_0000, ~k[0]}, {31'h0000_0000, tclk[3]});
    end
    sdd_peer_i.pin(3, 1'b0);
    $display("test external clock done");
    apb(0, 20'h0_0001, '0, '0);
    chk("unmapped error", 32'h0000_0001, {31'h0000_0000, sl});
    chk("unmapped data", 32'h0000_0000, rv);
    $display("test unmapped done");
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    apb(0, sdd_pkg::IDX_STAT, '0, '0);
    chk("status after reset", 32'h0000_0000, rv);
    apb(0, sdd_pkg::IDX_DATA[0], '0, '0);
    chk("data after reset", 32'h0000_0000, rv);
    chk("enabled after reset", 32'h0000_0000, {28'h000_0000, en});
    $display("test mid reset done");
    complete_run;
  end
endmodule // serial_data_divider_and_flag_clear_tb
